// *** verilog/ddrt_defines.svh ***
`ifndef DDRT_DEFINES_SVH
`define DDRT_DEFINES_SVH

// Clock period in ns at 50 MHz
`define DDRT_CLK_PERIOD_NS 20
// Write start offset after write latency, full burst or on-the-fly chop
`define DDRT_WSTART_BL8 5'h04
// Write start offset after write latency, chop fixed by mode register
`define DDRT_WSTART_BC4 5'h02
// Impedance short calibration duration in cycles
`define DDRT_ZQ_SHORT_CYCLES 8'h40
// Row activation or precharge busy time in cycles
`define DDRT_ROW_OP_CYCLES 8'h10
// Refresh busy time in cycles
`define DDRT_REFRESH_CYCLES 8'h20
// Read with auto-precharge: burst tail before the precharge starts
`define DDRT_READ_TAIL_CYCLES 8'h04
// Termination control latency is write latency minus this
`define DDRT_ODT_LAT_OFFSET 4'h2
// Depth of the write start scheduler
`define DDRT_WSCHED_DEPTH 24

`endif

// *** verilog/ddrt_pkg.sv ***
package ddrt_pkg;
  // Decoded command registered on a clock edge
  typedef enum logic [3:0] {
    DDRT_NOP, DDRT_ACT, DDRT_PRE, DDRT_REF, DDRT_WR, DDRT_WRA,
    DDRT_RD, DDRT_RDA, DDRT_MRS, DDRT_ZQS
  } ddrt_cmd_t;
  // Burst setting from mode register zero
  typedef enum logic [1:0] {
    DDRT_BL8_FIXED, DDRT_BURST_OTF, DDRT_BC4_FIXED
  } ddrt_burst_t;
endpackage

// *** verilog/ddrt_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ddrt_defines.svh"
module ddrt_timer (
  input wire logic clk_i,          // System clock
  input wire logic resetn_i,       // Sync reset, active low
  input wire logic load_i,         // Request to start or extend
  input wire logic [7:0] value_i,  // Cycles to stay busy
  output logic busy_o,             // Registered busy level
  output logic done_o              // One-cycle pulse at the end
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;

  // Load only extends, so overlapping operations end at the latest finish
  always_comb begin
    count_next = (count_reg != 8'h00) ? count_reg - 8'h01 : 8'h00;
    if (load_i && (value_i > count_next)) begin
      count_next = value_i;
    end
    busy_next = (count_next != 8'h00);
    done_next = (count_reg == 8'h01) && (count_next == 8'h00);
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      count_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;
endmodule
`default_nettype wire

// *** verilog/ddrt_core.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ddrt_defines.svh"
module ddrt_core (
  input wire logic clk_i,                    // System clock, the memory clock
  input wire logic resetn_i,                 // Sync reset, active low
  input wire ddrt_pkg::ddrt_cmd_t cmd_i,     // Command registered this edge
  input wire logic cke_i,                    // Clock enable as registered
  input wire logic odt_i,                    // Termination control as registered
  input wire logic [3:0] wl_i,               // Write latency in cycles
  input wire ddrt_pkg::ddrt_burst_t burst_i, // Burst setting
  input wire logic [4:0] wr_cycles_i,        // Write recovery from mode register zero
  input wire logic pd_dll_frozen_i,          // Precharge power-down freezes the DLL
  output logic write_start_o,                // Pulse: internal write begins
  output logic pd_state_o,                   // Power-down state applies
  output logic op_busy_o,                    // Row, precharge or refresh in progress
  output logic term_on_o,                    // Termination enabled
  output logic term_async_o,                 // Termination in asynchronous mode
  output logic zq_busy_o,                    // Short calibration running
  output logic zq_done_o                     // Pulse: short calibration complete
);
  import ddrt_pkg::*;

  localparam int WD = `DDRT_WSCHED_DEPTH;

  logic [WD-1:0] wsched_reg;
  logic [WD-1:0] wsched_next;
  logic wstart_reg;
  logic wstart_next;
  logic pd_reg;
  logic pd_next;
  logic bank_open_reg;
  logic bank_open_next;
  logic [15:0] odt_hist_reg;
  logic [15:0] odt_hist_next;
  logic term_on_reg;
  logic term_on_next;
  logic term_async_reg;
  logic term_async_next;
  logic op_load;
  logic [7:0] op_value;
  logic op_busy;
  logic zq_load;

  // Delay from write command to internal write start
  function automatic logic [4:0] wstart_delay(input logic [3:0] wl, input ddrt_burst_t b);
    logic [4:0] extra;
    extra = (b == DDRT_BC4_FIXED) ? `DDRT_WSTART_BC4 : `DDRT_WSTART_BL8;
    return {1'b0, wl} + extra;
  endfunction

  function automatic logic is_write(input ddrt_cmd_t c);
    return (c == DDRT_WR) || (c == DDRT_WRA);
  endfunction

  // write start scheduling: a one-hot slot per write lets bursts overlap
  always_comb begin
    wsched_next = wsched_reg >> 1;
    if (is_write(cmd_i)) begin
      wsched_next = wsched_next | (WD'(1) << (wstart_delay(wl_i, burst_i) - 5'h01));
    end
    wstart_next = wsched_reg[0];
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wsched_reg <= '0;
      wstart_reg <= 1'b0;
    end else begin
      wsched_reg <= wsched_next;
      wstart_reg <= wstart_next;
    end
  end

  // write with auto-precharge waits write recovery from mode register zero
  always_comb begin
    op_load = 1'b1;
    unique case (cmd_i)
      DDRT_ACT, DDRT_PRE: op_value = `DDRT_ROW_OP_CYCLES;
      DDRT_REF: op_value = `DDRT_REFRESH_CYCLES;
      DDRT_WRA: op_value = {3'h0, wstart_delay(wl_i, burst_i)} + {3'h0, wr_cycles_i}
                           + `DDRT_ROW_OP_CYCLES;
      DDRT_RDA: op_value = `DDRT_READ_TAIL_CYCLES + `DDRT_ROW_OP_CYCLES;
      default: begin
        op_load = 1'b0;
        op_value = 8'h00;
      end
    endcase
  end

  // Busy tracker for operations that outlive clock enable going low
  ddrt_timer u_op_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(op_load),
    .value_i(op_value),
    .busy_o(op_busy),
    .done_o()
  );

  // short calibration timer, fixed length at any clock rate
  assign zq_load = (cmd_i == DDRT_ZQS);
  ddrt_timer u_zq_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(zq_load),
    .value_i(`DDRT_ZQ_SHORT_CYCLES),
    .busy_o(zq_busy_o),
    .done_o(zq_done_o)
  );

  // power-down state waits for the busy operation to drain
  // no watchdog: any gap between edges leaves the state as it is
  always_comb begin
    pd_next = !cke_i && !op_busy && !op_load;
    bank_open_next = bank_open_reg;
    if (cmd_i == DDRT_ACT) begin
      bank_open_next = 1'b1;
    end else if ((cmd_i == DDRT_PRE) || (cmd_i == DDRT_WRA) || (cmd_i == DDRT_RDA)) begin
      bank_open_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pd_reg <= 1'b0;
      bank_open_reg <= 1'b0;
    end else begin
      pd_reg <= pd_next;
      bank_open_reg <= bank_open_next;
    end
  end

  // termination: async on entry and during frozen-DLL precharge power-down
  always_comb begin
    odt_hist_next = {odt_hist_reg[14:0], odt_i};
    term_async_next = !cke_i && pd_dll_frozen_i && !bank_open_next;
    if (term_async_next || (wl_i <= `DDRT_ODT_LAT_OFFSET)) begin
      term_on_next = odt_i;
    end else begin
      term_on_next = odt_hist_reg[wl_i - `DDRT_ODT_LAT_OFFSET - 4'h1];
    end
  end

  // Sync path follows termination control by the write latency minus two
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      odt_hist_reg <= 16'h0000;
      term_on_reg <= 1'b0;
      term_async_reg <= 1'b0;
    end else begin
      odt_hist_reg <= odt_hist_next;
      term_on_reg <= term_on_next;
      term_async_reg <= term_async_next;
    end
  end

  // Output drive from registers only
  assign write_start_o = wstart_reg;
  assign pd_state_o = pd_reg;
  assign op_busy_o = op_busy;
  assign term_on_o = term_on_reg;
  assign term_async_o = term_async_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // full burst write starts nine cycles after a latency-five write
  wstart_bl8_a: assert property (
    (is_write(cmd_i) && wl_i == 4'h5 && burst_i != DDRT_BC4_FIXED) |-> ##10 write_start_o)
    else $error("write start missing after full burst write");
  wstart_bc4_a: assert property (
    (is_write(cmd_i) && wl_i == 4'h5 && burst_i == DDRT_BC4_FIXED) |-> ##8 write_start_o)
    else $error("write start missing after fixed chop write");
  // calibration ends within the fixed window
  zq_finish_a: assert property (
    (zq_load && !zq_busy_o) |-> ##[64:66] zq_done_o)
    else $error("short calibration not done in time");
  zq_hold_a: assert property (
    (zq_load && !zq_busy_o) |=> zq_busy_o [*8])
    else $error("short calibration dropped busy early");
  // no power-down state while an operation is in progress
  pd_block_a: assert property (
    (op_busy && !cke_i) |=> !pd_state_o)
    else $error("power-down applied during busy operation");
  // auto-precharge write stays busy for at least the eight cycles after the command
  wra_hold_a: assert property (
    (cmd_i == DDRT_WRA) |=> op_busy_o [*8])
    else $error("auto-precharge write not held busy");
  // asynchronous termination follows control without latency
  async_term_a: assert property (
    (term_async_next && odt_i) |=> (term_on_o && term_async_o))
    else $error("async termination did not follow control");
  // a long idle gap changes nothing
  idle_stable_a: assert property (
    (cmd_i == DDRT_NOP && cke_i && !op_busy && wsched_reg == '0) |=> !pd_state_o && !op_busy_o)
    else $error("state changed during idle");

  // back-to-back writes at minimum spacing are accepted
  wr_pair_c: cover property (is_write(cmd_i) ##4 is_write(cmd_i) ##[1:30] write_start_o);
  pd_entry_c: cover property (op_busy && !cke_i ##[1:40] pd_state_o);
  zq_run_c: cover property (zq_load ##[64:66] zq_done_o);
  async_c: cover property (term_async_o && term_on_o);
endmodule
`default_nettype wire

// *** tb/ddrt_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ddrt_defines.svh"
module ddrt_ctrl_model (
  input wire logic clk_i,                   // Memory clock
  output var ddrt_pkg::ddrt_cmd_t cmd_o,    // Command per edge
  output logic cke_o,                       // Clock enable
  output logic odt_o,                       // Termination control
  output logic [3:0] wl_o,                  // Write latency
  output var ddrt_pkg::ddrt_burst_t burst_o, // Burst setting
  output logic [4:0] wr_o,                  // Write recovery cycles
  output logic frz_o                        // Power-down freezes the DLL
);
  import ddrt_pkg::*;
  // Quiet controller at time zero
  initial begin
    cmd_o = DDRT_NOP;
    cke_o = 1'b1;
    odt_o = 1'b0;
    wl_o = 4'h5;
    burst_o = DDRT_BL8_FIXED;
    wr_o = 5'h06;
    frz_o = 1'b0;
  end
  task automatic send(input ddrt_cmd_t c);
    @(posedge clk_i) cmd_o <= c;
    @(posedge clk_i) cmd_o <= DDRT_NOP;
  endtask
  task automatic lvl(input logic cke, input logic frz, input logic [3:0] wl,
                     input ddrt_burst_t b);
    logic wake;
    wake = cke && !cke_o;
    @(posedge clk_i);
    cke_o <= cke;
    frz_o <= frz;
    wl_o <= wl;
    burst_o <= b;
    if (wake) repeat (10) @(posedge clk_i);
  endtask
  // Raise termination control
  task automatic odt_on();
    @(posedge clk_i) odt_o <= 1'b1;
  endtask
  // held high past the long minimum
  task automatic odt_off();
    repeat (6) @(posedge clk_i);
    odt_o <= 1'b0;
  endtask
  // Arbitrary write recovery minimum in ns, plain default
  localparam int TWR_NS = 15;
  // write recovery rounded up to whole cycles before clock enable drops
  task automatic wr_recover();
    repeat ((TWR_NS + `DDRT_CLK_PERIOD_NS - 1) / `DDRT_CLK_PERIOD_NS) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ddrt_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  ddrt_cmd_t cmd;
  ddrt_burst_t burst;
  logic cke;
  logic odt;
  logic frz;
  logic [3:0] wl;
  logic [4:0] wr;
  wire logic [6:0] outs;
  int bad_count = 0;
  int samples_checked = 0;
  // Free-running 50 MHz clock
  always #10 clk_i = ~clk_i;
  // Device and its controller; outs packs the outputs for shared waits
  ddrt_core u_ddrt_core (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_i(cmd), .cke_i(cke),
    .odt_i(odt), .wl_i(wl), .burst_i(burst), .wr_cycles_i(wr), .pd_dll_frozen_i(frz),
    .write_start_o(outs[0]), .pd_state_o(outs[1]), .op_busy_o(outs[2]), .term_on_o(outs[3]),
    .term_async_o(outs[4]), .zq_busy_o(outs[5]), .zq_done_o(outs[6]));
  ddrt_ctrl_model u_ddrt_ctrl_model (.clk_i(clk_i), .cmd_o(cmd), .cke_o(cke), .odt_o(odt),
    .wl_o(wl), .burst_o(burst), .wr_o(wr), .frz_o(frz));
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One line per mismatch
  task automatic fail(input string m);
    bad_count++;
    $display("Error at %0t: %s", $time, m);
  endtask
  // Counts edges until an output reaches a level; a hang ends the run
  task automatic wait_for(input int i, input logic v, output int k);
    k = 0;
    #1;
    while (outs[i] !== v && k < 300) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (k >= 300) begin
      bad_count++;
      final_report();
    end
  endtask
  // Internal write start offset and pulse width, then power-down entry after it
  task automatic t_write(input ddrt_burst_t b, input logic [3:0] w, input int d);
    int k;
    u_ddrt_ctrl_model.lvl(1'b1, 1'b0, w, b);
    u_ddrt_ctrl_model.send(DDRT_WR);
    wait_for(0, 1'b1, k);
    samples_checked++;
    if (k != int'(w) + d) fail("write start offset");
    @(posedge clk_i);
    #1;
    samples_checked++;
    if (outs[0] !== 1'b0) fail("write start width");
    u_ddrt_ctrl_model.wr_recover();
    u_ddrt_ctrl_model.lvl(1'b0, 1'b0, w, b);
    @(posedge clk_i);
    #1;
    samples_checked++;
    if (outs[1] !== 1'b1) fail("power-down after write");
  endtask
  // Short calibration length and done pulse, clock enable high first
  task automatic t_zq();
    int k;
    u_ddrt_ctrl_model.lvl(1'b1, 1'b0, 4'h5, DDRT_BL8_FIXED);
    u_ddrt_ctrl_model.send(DDRT_ZQS);
    #1;
    samples_checked++;
    if (outs[5] !== 1'b1) fail("calibration busy");
    wait_for(6, 1'b1, k);
    samples_checked++;
    if (k != 64 || outs[5] !== 1'b0) fail("calibration length");
    @(posedge clk_i);
    #1;
    samples_checked++;
    if (outs[6] !== 1'b0) fail("calibration done width");
  endtask
  // Command first, clock enable low g + 2 edges later while it is still busy
  task automatic t_busy(input ddrt_cmd_t c, input int n, input int g);
    int k;
    u_ddrt_ctrl_model.lvl(1'b1, 1'b0, 4'h5, DDRT_BL8_FIXED);
    u_ddrt_ctrl_model.send(c);
    repeat (g) @(posedge clk_i);
    u_ddrt_ctrl_model.lvl(1'b0, 1'b0, 4'h5, DDRT_BL8_FIXED);
    #1;
    samples_checked++;
    if (outs[2] !== 1'b1 || outs[1] !== 1'b0) fail("busy start");
    wait_for(2, 1'b0, k);
    samples_checked++;
    if (k != n - g - 1 || outs[1] !== 1'b0) fail("busy length");
    @(posedge clk_i);
    #1;
    samples_checked++;
    if (outs[1] !== 1'b1) fail("power-down after busy");
  endtask
  // Synchronous termination latency, then asynchronous in frozen power-down
  task automatic t_term();
    int k;
    u_ddrt_ctrl_model.lvl(1'b1, 1'b1, 4'h5, DDRT_BL8_FIXED);
    u_ddrt_ctrl_model.odt_on();
    wait_for(3, 1'b1, k);
    samples_checked++;
    if (k != 4 || outs[4] !== 1'b0) fail("sync termination on");
    u_ddrt_ctrl_model.odt_off();
    wait_for(3, 1'b0, k);
    samples_checked++;
    if (k != 4) fail("sync termination off");
    u_ddrt_ctrl_model.send(DDRT_PRE);
    u_ddrt_ctrl_model.lvl(1'b0, 1'b1, 4'h5, DDRT_BL8_FIXED);
    u_ddrt_ctrl_model.odt_on();
    @(posedge clk_i);
    #1;
    samples_checked++;
    if (outs[4] !== 1'b1 || outs[3] !== 1'b1) fail("async termination on");
    u_ddrt_ctrl_model.odt_off();
    @(posedge clk_i);
    #1;
    samples_checked++;
    if (outs[3] !== 1'b0) fail("async termination off");
  endtask
  // Main sequence, ending with a reset in mid-calibration and a release
  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    samples_checked++;
    if (outs !== 7'h00) fail("outputs in reset");
    @(posedge clk_i) resetn_i <= 1'b1;
    t_write(DDRT_BL8_FIXED, 4'h5, 4);
    t_write(DDRT_BURST_OTF, 4'hc, 4);
    t_write(DDRT_BC4_FIXED, 4'h5, 2);
    t_zq();
    t_busy(DDRT_ACT, 16, 0);
    t_busy(DDRT_REF, 32, 0);
    t_busy(DDRT_RDA, 20, 0);
    t_busy(DDRT_WRA, 31, 5 + 4 + 6 + 1 - 2);
    t_term();
    u_ddrt_ctrl_model.lvl(1'b1, 1'b0, 4'h5, DDRT_BL8_FIXED);
    u_ddrt_ctrl_model.send(DDRT_ZQS);
    @(posedge clk_i) resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    samples_checked++;
    if (outs !== 7'h00) fail("outputs after second reset");
    @(posedge clk_i) resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    samples_checked++;
    if (outs !== 7'h00) fail("calibration left after reset");
    final_report();
  end
endmodule
`default_nettype wire
